// ===== core/serial_pin_mux_pkg.sv
// constants for the serial control pin mux of the second sync serial port
// assumes a single system clock domain and no register bus
package serial_pin_mux_pkg;
  localparam int          NUM_PINS      = 3;
  localparam int          PIN_ZERO      = 0;
  localparam int          PIN_ONE       = 1;
  localparam int          PIN_TWO       = 2;
  localparam logic [2:0]  FUNC_SEL_RST  = 3'h0;
  localparam logic [2:0]  PORT_DIR_RST  = 3'h0;
  localparam logic [2:0]  PORT_OUT_RST  = 3'h0;
  localparam logic        MODE_SYNC     = 1'h1;
  localparam logic        MODE_ASYNC    = 1'h0;
  localparam int          SYNC_STAGES   = 2;
endpackage

// ===== core/serial_port_control_pin_mux.sv
// pin mux for the three serial control pins and the serial bit clock pin
// assumes pins are resolved by the bench from out/oe; pin inputs are async
//
// Summary of operation
// [R01] async mode: pin zero is the receive clock, driven out or taken in.
// [R02] sync mode: pin zero is extra transmitter one output or serial flag zero.
// [R03] async mode: pin one is the receiver frame sync, driven out or taken in.
// [R04] sync mode: pin one is extra transmitter two output or serial flag one.
// [R05] pin two is frame sync for tx and rx in sync mode, tx only in async mode.
// [R06] pin two as output drives the internally generated frame sync.
// [R07] pin two as input takes the external frame sync for tx, and rx when sync.
// [R08] after reset all three pins are general-purpose port inputs.
// [R09] in port role a pin's direction follows its port direction bit.
// [R10] a port function select bit moves its pin to the serial function.
// [R11] bit clock pin clocks tx and rx in sync mode, tx only in async mode.
// [R12] in serial role the serial settings set the enable, not the port bit.
`timescale 1ns/1ps
`default_nettype none
module serial_port_control_pin_mux
  import serial_pin_mux_pkg::*;
(
  input  wire logic                mclk,               // system clock, 125 MHz
  input  wire logic                rst_b,              // sync reset, active low
  input  wire logic [2:0]          port_function_select_reg, // 1 = serial role
  input  wire logic [2:0]          port_direction_reg, // 1 = port line output
  input  wire logic [2:0]          port_line_out,      // port data to drive
  input  wire logic                sync_mode,          // 1 sync, 0 async
  input  wire logic                pin0_sel_flag,      // sync: pin zero is flag
  input  wire logic                pin1_sel_flag,      // sync: pin one is flag
  input  wire logic                pin0_dir_out,       // serial: pin zero drives
  input  wire logic                pin1_dir_out,       // serial: pin one drives
  input  wire logic                pin2_dir_out,       // serial: pin two drives
  input  wire logic                tx1_data,           // extra transmitter one
  input  wire logic                tx2_data,           // extra transmitter two
  input  wire logic                flag0_out,          // serial flag zero value
  input  wire logic                flag1_out,          // serial flag one value
  input  wire logic                rx_clk_gen,         // internal receive clock
  input  wire logic                rx_fs_gen,          // internal receive fsync
  input  wire logic                tx_fs_gen,          // internal frame sync
  input  wire logic                bit_clk_in,         // serial_bit_clock_pin in
  input  wire logic [2:0]          serial_ctrl_pin_in, // pin levels, async
  output logic      [2:0]          serial_ctrl_pin_out, // pin drive values
  output logic      [2:0]          serial_ctrl_pin_oe,  // 1 = drive pin
  output logic      [2:0]          port_line_in,       // port line read-back
  output logic                     flag0_in,           // serial flag zero seen
  output logic                     flag1_in,           // serial flag one seen
  output logic                     rx_clk,             // receiver clock
  output logic                     rx_fs,              // receiver frame sync
  output logic                     tx_clk,             // transmitter clock
  output logic                     tx_fs               // transmitter frame sync
);
  import serial_pin_mux_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] meta_q, meta_d;
  logic [3:0] sync_q, sync_d;
  always_comb begin
    meta_d = {bit_clk_in, serial_ctrl_pin_in};
    sync_d = meta_q;
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  wire logic [2:0] pin_s = sync_q[2:0];
  wire logic       bclk_s = sync_q[3];

  // ----------------------------------------------------------------
  // pin drive and enable
  // ----------------------------------------------------------------
  logic [2:0] out_q, out_d, oe_q, oe_d;
  logic [2:0] ser_out, ser_oe;
  always_comb begin
    if (sync_mode == MODE_SYNC) begin
      ser_out[PIN_ZERO] = pin0_sel_flag ? flag0_out : tx1_data; // R02
      ser_out[PIN_ONE]  = pin1_sel_flag ? flag1_out : tx2_data; // R04
    end else begin
      ser_out[PIN_ZERO] = rx_clk_gen; // R01
      ser_out[PIN_ONE]  = rx_fs_gen; // R03
    end
    ser_out[PIN_TWO] = tx_fs_gen; // R06
    ser_oe = {pin2_dir_out, pin1_dir_out, pin0_dir_out}; // R12
    for (int i = 0; i < NUM_PINS; i++) begin
      if (port_function_select_reg[i]) begin // R10
        out_d[i] = ser_out[i];
        oe_d[i]  = ser_oe[i]; // R12
      end else begin
        out_d[i] = port_line_out[i];
        oe_d[i]  = port_direction_reg[i]; // R09
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      out_q <= PORT_OUT_RST;
      oe_q  <= PORT_DIR_RST; // R08
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end
  assign serial_ctrl_pin_out = out_q;
  assign serial_ctrl_pin_oe  = oe_q;

  // ----------------------------------------------------------------
  // inbound routing
  // ----------------------------------------------------------------
  logic [2:0] pin_in_q, pin_in_d;
  logic       f0_q, f0_d, f1_q, f1_d;
  logic       rck_q, rck_d, rfs_q, rfs_d, tck_q, tck_d, tfs_q, tfs_d;
  always_comb begin
    pin_in_d = pin_s;
    f0_d  = (sync_mode == MODE_SYNC) && pin0_sel_flag && pin_s[PIN_ZERO]; // R02
    f1_d  = (sync_mode == MODE_SYNC) && pin1_sel_flag && pin_s[PIN_ONE]; // R04
    tck_d = bclk_s; // R11
    // fsync source: own generator when pin2_dir_out is set, pin otherwise
    tfs_d = pin2_dir_out ? tx_fs_gen : pin_s[PIN_TWO]; // R07
    if (sync_mode == MODE_SYNC) begin
      rck_d = bclk_s; // R11
      rfs_d = tfs_d; // R05
    end else begin
      rck_d = pin0_dir_out ? rx_clk_gen : pin_s[PIN_ZERO]; // R01
      rfs_d = pin1_dir_out ? rx_fs_gen : pin_s[PIN_ONE]; // R03
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pin_in_q <= 3'h0;
      f0_q <= 1'h0;
      f1_q <= 1'h0;
      rck_q <= 1'h0;
      rfs_q <= 1'h0;
      tck_q <= 1'h0;
      tfs_q <= 1'h0;
    end else begin
      pin_in_q <= pin_in_d;
      f0_q <= f0_d;
      f1_q <= f1_d;
      rck_q <= rck_d;
      rfs_q <= rfs_d;
      tck_q <= tck_d;
      tfs_q <= tfs_d;
    end
  end
  assign port_line_in = pin_in_q;
  assign flag0_in = f0_q;
  assign flag1_in = f1_q;
  assign rx_clk = rck_q;
  assign rx_fs = rfs_q;
  assign tx_clk = tck_q;
  assign tx_fs = tfs_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_reset_release;
    !$past(rst_b) ##0 rst_b;
  endsequence

  // pin levels need two sync stages and the read-back register
  sequence s_pin_readback;
    ##3 pin_in_q == $past(serial_ctrl_pin_in, 3);
  endsequence

  AST_RESET_INPUTS: assert property (s_reset_release |-> oe_q == 3'h0) // R08
    else $error("pins not inputs after reset");
  AST_PORT_DIR: assert property ( // R09
      !port_function_select_reg[0]
      |=> oe_q[0] == $past(port_direction_reg[0]))
    else $error("port direction not followed");
  AST_PORT_OUT: assert property ( // R09
      !port_function_select_reg[PIN_TWO]
      |=> out_q[PIN_TWO] == $past(port_line_out[PIN_TWO]))
    else $error("port value not driven on pin two");
  AST_PIN_READBACK: assert property (rst_b |-> s_pin_readback) // R09
    else $error("port line read-back out of step with pin");
  AST_SER_OE: assert property ( // R12
      port_function_select_reg[2]
      |=> oe_q[2] == $past(pin2_dir_out))
    else $error("serial enable wrong on pin two");
  AST_SEL_SWITCH: assert property ( // R10
      port_function_select_reg[1] && !sync_mode
      |=> out_q[1] == $past(rx_fs_gen))
    else $error("select bit did not switch function");
  AST_ASYNC_RCK: assert property ( // R01
      !sync_mode && !pin0_dir_out
      |=> rck_q == $past(pin_s[0]))
    else $error("async receive clock not from pin zero");
  AST_ASYNC_PIN0: assert property ( // R01
      port_function_select_reg[PIN_ZERO] && !sync_mode
      |=> out_q[PIN_ZERO] == $past(rx_clk_gen))
    else $error("async pin zero not the receive clock");
  AST_ASYNC_RFS: assert property ( // R03
      !sync_mode && !pin1_dir_out
      |=> rfs_q == $past(pin_s[PIN_ONE]))
    else $error("async receive frame sync not from pin one");
  AST_SYNC_PIN0: assert property ( // R02
      sync_mode && port_function_select_reg[0] && !pin0_sel_flag
      |=> out_q[0] == $past(tx1_data))
    else $error("pin zero not tx one");
  AST_SYNC_PIN1: assert property ( // R04
      sync_mode && port_function_select_reg[1] && pin1_sel_flag
      |=> out_q[1] == $past(flag1_out))
    else $error("pin one not flag one");
  AST_FLAG_IN: assert property ( // R02
      sync_mode && pin0_sel_flag
      |=> f0_q == $past(pin_s[PIN_ZERO]))
    else $error("flag zero not read from pin zero");
  AST_FLAG_ASYNC: assert property ( // R02
      !sync_mode
      |=> !f0_q && !f1_q)
    else $error("flag seen in async mode");
  AST_FS_OUT: assert property ( // R06
      port_function_select_reg[2]
      |=> out_q[2] == $past(tx_fs_gen))
    else $error("frame sync not driven");
  AST_TX_FS_GEN: assert property ( // R06
      pin2_dir_out
      |=> tfs_q == $past(tx_fs_gen))
    else $error("own frame sync not used when driving");
  AST_TX_FS_IN: assert property ( // R07
      !pin2_dir_out
      |=> tfs_q == $past(pin_s[PIN_TWO]))
    else $error("external frame sync not taken from pin two");
  AST_SYNC_RFS: assert property (sync_mode |=> rfs_q == $past(tfs_d)) // R05
    else $error("sync receive frame sync differs");
  AST_SYNC_RCK: assert property (sync_mode |=> rck_q == tck_q) // R11
    else $error("sync receive clock differs");
  AST_TX_CLK: assert property (rst_b |=> tck_q == $past(bclk_s)) // R11
    else $error("transmit clock not the bit clock");
endmodule
`default_nettype wire

// ===== verification/serial_far_end.sv
// far-end serial device: frame sync, rx clock and flag levels, bit clock
// assumes the bench resolves each pin from the device's enable alone
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
  input  wire logic       run,     // bit clock running
  input  wire logic [2:0] lvl,     // levels to put on pins
  output logic      [2:0] drv,     // pin drive values
  output logic            bit_clk  // serial bit clock
);
  // -------------------------------------------
  // pins and clock
  // -------------------------------------------
  assign drv = lvl;
  // clock stands low while run is low
  initial bit_clk = 1'b0;
  always #62.5 bit_clk = run ? ~bit_clk : 1'b0;
endmodule
`default_nettype wire

// ===== verification/serial_port_control_pin_mux_tb.sv
// bench for the serial control pin mux
// assumes the far end only drives a pin that the device leaves undriven
`timescale 1ns/1ps
`default_nettype none
module serial_port_control_pin_mux_tb;
  logic mclk = 0, rst_b = 0, run = 0, rc, rf, tc, tf, fi0, fi1, bclk, rp, tp;
  logic sm = 0, f0s = 0, f1s = 0, d0 = 0, d1 = 0, d2 = 0, t1 = 0, t2 = 0;
  logic fo0 = 0, fo1 = 0, rcg = 0, rfg = 0, tfg = 0;
  logic [2:0] sel = 0, dir = 0, pout = 0, pval = 0, pdrv, out, oe, lin, pin;
  int failures = 0, comparisons = 0, cyc = 0, nr, nt;
  always #4 mclk = ~mclk;
  assign pin = (oe & out) | (~oe & pdrv);
  serial_far_end far (.run(run), .lvl(pval), .drv(pdrv), .bit_clk(bclk));
  serial_port_control_pin_mux dut (.mclk(mclk), .rst_b(rst_b),
    .port_function_select_reg(sel), .port_direction_reg(dir), .port_line_out(pout),
    .sync_mode(sm), .pin0_sel_flag(f0s), .pin1_sel_flag(f1s), .pin0_dir_out(d0),
    .pin1_dir_out(d1), .pin2_dir_out(d2), .tx1_data(t1), .tx2_data(t2),
    .flag0_out(fo0), .flag1_out(fo1), .rx_clk_gen(rcg), .rx_fs_gen(rfg),
    .tx_fs_gen(tfg), .bit_clk_in(bclk), .serial_ctrl_pin_in(pin),
    .serial_ctrl_pin_out(out), .serial_ctrl_pin_oe(oe), .port_line_in(lin),
    .flag0_in(fi0), .flag1_in(fi1), .rx_clk(rc), .rx_fs(rf), .tx_clk(tc), .tx_fs(tf));
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  task chk(string n, logic [3:0] s, logic [3:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // returns on the edge; reads there see the last settled outputs
  task w(int n);
    repeat (n) @(posedge mclk);
  endtask
  task finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // edge counts of the recovered clocks
  always @(posedge mclk) begin
    rp <= rc;
    tp <= tc;
    nr += int'(rc & !rp);
    nt += int'(tc & !tp);
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test();
    end
  end
  // -------------------------------------------
  // tests
  // -------------------------------------------
  initial begin
    w(3); rst_b <= 1'b1; w(2);
    chk("oe", oe, 4'h0);
    chk("rx", {rc, rf, tf}, 4'h0);
    $display("reset test done");
    dir <= 3'h5; pout <= 3'h7; pval <= 3'h2; w(5);
    chk("oe", oe, 4'h5);
    chk("drv", out & oe, 4'h5);
    chk("lin", lin, 4'h7);
    $display("port test done");
    sel <= 3'h7; sm <= 1'b1; dir <= 3'h0; {d0, d1, d2, t1, tfg} <= 5'h1f; w(3);
    chk("oe", oe, 4'h7);
    chk("out", out, 4'h5);
    chk("tf", tf, 4'h1);
    {f0s, f1s, fo1} <= 3'h7; w(3);
    chk("out", out, 4'h6);
    {d0, d1, dir} <= 5'h07; pval <= 3'h1; w(5);
    chk("oe", oe, 4'h4);
    chk("flg", {fi1, fi0}, 4'h1);
    // own frame sync low, so a high here can only come from the far end
    d2 <= 1'b0; tfg <= 1'b0; pval <= 3'h4; w(5);
    chk("fs", {rf, tf}, 4'h3);
    $display("sync test done");
    sm <= 1'b0; pval <= 3'h3; w(5);
    chk("afs", {rc, rf, tf}, 4'h6);
    {d0, d1, rfg} <= 3'h7; w(3);
    chk("agen", {rc, rf, out[1:0]}, 4'h6);
    $display("async test done");
    run <= 1'b1; w(2); nr = 0; nt = 0; w(100);
    chk("actc", {nt > 3, nr == 0}, 4'h3);
    sm <= 1'b1; w(4); nr = 0; w(100);
    chk("sclk", nr > 3, 4'h1);
    $display("clock test done");
    finish_test();
  end
endmodule
`default_nettype wire
